// ### rtl/ts_time_stamp_recorder.v
// What this block does
// R1: In RAM-mode 0 each stamp latches sub-second counter: 1/512,1/1024 at 0x20, 1/2..1/256 at 0x21.
// R2: In RAM-mode 0 each stamp copies seconds through year into 0x22..0x28, status snapshot into 0x29.
// R3: Snapshot bit5 battery low, bit4 supply below battery, bit3 detect, bit1 osc stop.
// R4: Snapshot osc-stop bit is 0 when oscillating, 1 when stopped at the event.
// R5: Stamps come from the event pin and from enabled internal monitor conditions.
// R6: In multi-record mode successive stamps go to record RAM, at most 8 records.
// R7: Host clears global enable before reading stamp data.
// R8: Supply-compare enable makes battery rising above supply a stamp event.
// R9: Supply-detect enable makes entry into backup mode a stamp event.
// R10: Host waits 31.25 ms after initial-power enable before supply-detect enable.
// R11: Battery-low enable gates both battery-low detection and its stamp event.
// R12: Oscillator-stop enable makes a detected oscillator stop a stamp event.
// R13: RAM records hold every stamped field except 1/1024 part and weekday.
// R14: RAM-mode 0 gives plain RAM and stamp registers; 1 gives record RAM.
// R15: Writing 1 to record-clear resets status to full 0, empty 1, pointer 111.
// R16: Host clears global enable before issuing a record-clear.
// R17: Interrupt select 0 pulses on every stamp; 1 only when eighth record stored.
// R18: Full flag reads 1 once eight records are held, else 0.
// R19: Empty flag reads 1 with no record held, 0 after one is stored.
// R20: Three-bit pointer names newest slot at 0x40 plus 8n, default 111.
// R21: Each record advances pointer modulo eight, writes slot, updates empty and full.
// R22: While full, further stamps are ignored by record RAM until record-clear.
`timescale 1ns/100ps
`default_nettype none
`include "ts_consts.vh"

module ts_time_stamp_recorder #(
  parameter SUBSEC_WIDTH = 10,
  parameter RAM_DEPTH    = 64
) (
  input  wire                    sys_clk,
  input  wire                    rst,
  input  wire [7:0]              regAddr,
  input  wire [7:0]              regWrData,
  input  wire                    regWrite,
  input  wire                    regRead,
  output reg  [7:0]              regRdData,
  input  wire                    stampGlobalEnable,
  input  wire                    eventInputPin,
  input  wire                    batteryLowFlag,
  input  wire                    supplyBelowBatteryFlag,
  input  wire                    supplyDetectFlag,
  input  wire                    oscStopFlag,
  input  wire [SUBSEC_WIDTH-1:0] subsecCount,
  input  wire [7:0]              calSeconds,
  input  wire [7:0]              calMinutes,
  input  wire [7:0]              calHours,
  input  wire [7:0]              calWeekday,
  input  wire [7:0]              calDay,
  input  wire [7:0]              calMonth,
  input  wire [7:0]              calYear,
  output reg                     stampIrqPulse,
  output wire                    batteryLowDetected
);

  // Bits of the sub-second count below the 1/256 weight
  localparam SUB_SPLIT = SUBSEC_WIDTH - 8;

  // Stamp registers
  reg [7:0] stampSubsecLow;
  reg [7:0] stampSubsecHigh;
  reg [7:0] stampSeconds;
  reg [7:0] stampMinutes;
  reg [7:0] stampHours;
  reg [7:0] stampWeekday;
  reg [7:0] stampDay;
  reg [7:0] stampMonth;
  reg [7:0] stampYear;
  reg [7:0] stampStatusSnapshot;

  // Control and status
  reg                     irqOnFullSelect;
  reg                     recordRamMode;
  reg [`TS_SRC_WIDTH-1:0] sourceEnables;
  reg                     recordFull;
  reg                     recordEmpty;
  reg [2:0]               latestSlot;
  reg [3:0]               recordCount;

  // Record memory
  reg [7:0] recordRam [0:RAM_DEPTH-1];

  // Synchronised pins
  wire [4:0] rawLevels;
  wire [4:0] syncLevels;
  wire       pinLevel;
  wire       lowLevel;
  wire       cmpLevel;
  wire       detLevel;
  wire       oscLevel;
  reg  [4:0] prevLevels;

  wire       supplyCompareEnable;
  wire       supplyDetectEnable;
  wire       batteryLowEnable;
  wire       oscStopEnable;
  wire       pinEvent;
  wire       internalEvent;
  wire       stampEvent;
  wire       recordStore;
  wire       recordClear;
  reg  [7:0] snapshot;
  wire [2:0] storeSlot;
  wire [2:0] nextSlotAfterStore;
  wire [3:0] countBase;
  wire [3:0] next_recordCount;
  wire       eighthStored;
  wire [7:0] subsecLowByte;
  wire [7:0] subsecHighByte;
  reg  [7:0] ctrlByte;
  reg  [7:0] srcEnByte;
  reg  [7:0] statusByte;

  // Address decoding shared by writes and reads
  function isRamAddr;
    input [7:0] addr;
    begin
      isRamAddr = (addr >= `TS_ADDR_RAM_BASE) && (addr <= `TS_ADDR_RAM_LAST);
    end
  endfunction

  function [5:0] ramIndex;
    input [7:0] addr;
    begin
      ramIndex = addr[5:0];
    end
  endfunction

  assign rawLevels = {eventInputPin, batteryLowFlag, supplyBelowBatteryFlag, supplyDetectFlag, oscStopFlag};

  ts_pin_sync #(
    .WIDTH   (5)
  ) i_ts_pin_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .asyncIn (rawLevels),
    .syncOut (syncLevels)
  );

  assign pinLevel = syncLevels[4];
  assign lowLevel = syncLevels[3];
  assign cmpLevel = syncLevels[2];
  assign detLevel = syncLevels[1];
  assign oscLevel = syncLevels[0];

  assign supplyCompareEnable = sourceEnables[`TS_SRC_CMP];
  assign supplyDetectEnable  = sourceEnables[`TS_SRC_DET];
  assign batteryLowEnable    = sourceEnables[`TS_SRC_LOW];
  assign oscStopEnable       = sourceEnables[`TS_SRC_OSC];

  // Battery-low detection is only alive while enabled
  assign batteryLowDetected = batteryLowEnable & lowLevel; // R11

  always @(posedge sys_clk)
  begin
    if (rst)
      prevLevels <= 5'h00;
    else
      prevLevels <= syncLevels;
  end

  // Rising edges of the pin and of enabled monitor conditions
  assign pinEvent = pinLevel & ~prevLevels[4]; // R5
  assign internalEvent = (batteryLowEnable & lowLevel & ~prevLevels[3]) // R11
                       | (supplyCompareEnable & cmpLevel & ~prevLevels[2]) // R8
                       | (supplyDetectEnable & detLevel & ~prevLevels[1]) // R9
                       | (oscStopEnable & oscLevel & ~prevLevels[0]); // R12
  assign stampEvent = stampGlobalEnable & (pinEvent | internalEvent); // R5

  // Snapshot of monitor flags at the event
  always @*
  begin
    snapshot = `TS_BYTE_ZERO;
    snapshot[`TS_SNAP_LOW] = batteryLowDetected; // R3
    snapshot[`TS_SNAP_CMP] = cmpLevel;
    snapshot[`TS_SNAP_DET] = detLevel;
    snapshot[`TS_SNAP_OSC] = oscLevel; // R3 R4
  end

  assign recordClear = regWrite && (regAddr == `TS_ADDR_REC_CTRL) && regWrData[`TS_CTRL_CLEAR]; // R15
  // Stamps are dropped by record RAM while full; a same-cycle clear frees it first
  assign recordStore = stampEvent && recordRamMode && (recordClear || !recordFull); // R6 R22
  assign storeSlot = recordClear ? `TS_PTR_RESET : latestSlot;
  assign nextSlotAfterStore = storeSlot + `TS_PTR_STEP; // R21
  assign countBase = recordClear ? `TS_COUNT_ZERO : recordCount;
  assign next_recordCount = countBase + `TS_COUNT_STEP;
  assign eighthStored = recordStore && (next_recordCount == `TS_COUNT_FULL); // R17
  assign subsecLowByte  = {{(8-SUB_SPLIT){1'b0}}, subsecCount[SUB_SPLIT-1:0]}; // R1
  assign subsecHighByte = subsecCount[SUBSEC_WIDTH-1:SUB_SPLIT]; // R1

  // Stamp registers in single-stamp mode
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      stampSubsecLow      <= `TS_BYTE_ZERO;
      stampSubsecHigh     <= `TS_BYTE_ZERO;
      stampSeconds        <= `TS_BYTE_ZERO;
      stampMinutes        <= `TS_BYTE_ZERO;
      stampHours          <= `TS_BYTE_ZERO;
      stampWeekday        <= `TS_BYTE_ZERO;
      stampDay            <= `TS_BYTE_ZERO;
      stampMonth          <= `TS_BYTE_ZERO;
      stampYear           <= `TS_BYTE_ZERO;
      stampStatusSnapshot <= `TS_BYTE_ZERO;
    end
    else if (stampEvent && !recordRamMode) // R14
    begin
      stampSubsecLow      <= subsecLowByte; // R1
      stampSubsecHigh     <= subsecHighByte; // R1
      stampSeconds        <= calSeconds; // R2
      stampMinutes        <= calMinutes;
      stampHours          <= calHours;
      stampWeekday        <= calWeekday;
      stampDay            <= calDay;
      stampMonth          <= calMonth;
      stampYear           <= calYear;
      stampStatusSnapshot <= snapshot; // R2
    end
  end

  // Control registers
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      irqOnFullSelect <= 1'b0;
      recordRamMode   <= 1'b0;
      sourceEnables   <= {`TS_SRC_WIDTH{1'b0}};
    end
    else if (regWrite)
    begin
      if (regAddr == `TS_ADDR_REC_CTRL)
      begin
        irqOnFullSelect <= regWrData[`TS_CTRL_IRQ_SEL];
        recordRamMode   <= regWrData[`TS_CTRL_RAM_MODE]; // R14
      end
      if (regAddr == `TS_ADDR_SRC_EN)
        sourceEnables <= regWrData[`TS_SRC_WIDTH-1:0];
    end
  end

  // Record status; a store in the clear cycle still counts
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      recordFull  <= 1'b0;
      recordEmpty <= 1'b1;
      latestSlot  <= `TS_PTR_RESET;
      recordCount <= `TS_COUNT_ZERO;
    end
    else if (recordStore)
    begin
      latestSlot  <= nextSlotAfterStore; // R21 R20
      recordEmpty <= 1'b0; // R19
      recordCount <= next_recordCount;
      recordFull  <= (next_recordCount == `TS_COUNT_FULL); // R18
    end
    else if (recordClear)
    begin
      recordFull  <= 1'b0; // R15
      recordEmpty <= 1'b1;
      latestSlot  <= `TS_PTR_RESET;
      recordCount <= `TS_COUNT_ZERO;
    end
  end

  // Record RAM; a record store wins over a host write in the same cycle
  always @(posedge sys_clk)
  begin
    if (recordStore)
    begin
      recordRam[{nextSlotAfterStore, `TS_REC_SUBSEC}]  <= subsecHighByte; // R13
      recordRam[{nextSlotAfterStore, `TS_REC_SECONDS}] <= calSeconds;
      recordRam[{nextSlotAfterStore, `TS_REC_MINUTES}] <= calMinutes;
      recordRam[{nextSlotAfterStore, `TS_REC_HOURS}]   <= calHours;
      recordRam[{nextSlotAfterStore, `TS_REC_DAY}]     <= calDay;
      recordRam[{nextSlotAfterStore, `TS_REC_MONTH}]   <= calMonth;
      recordRam[{nextSlotAfterStore, `TS_REC_YEAR}]    <= calYear;
      recordRam[{nextSlotAfterStore, `TS_REC_STATUS}]  <= {snapshot[7:1], subsecCount[SUB_SPLIT-1]}; // R13
    end
    else if (regWrite && isRamAddr(regAddr)) // R14
      recordRam[ramIndex(regAddr)] <= regWrData;
  end

  // Interrupt pulse
  always @(posedge sys_clk)
  begin
    if (rst)
      stampIrqPulse <= 1'b0;
    else if (irqOnFullSelect)
      stampIrqPulse <= eighthStored; // R17
    else
      stampIrqPulse <= stampEvent; // R17
  end

  // Readback bytes assembled from their field positions
  always @*
  begin
    ctrlByte = `TS_BYTE_ZERO; // R15
    ctrlByte[`TS_CTRL_IRQ_SEL] = irqOnFullSelect;
    ctrlByte[`TS_CTRL_RAM_MODE] = recordRamMode;
    srcEnByte = `TS_BYTE_ZERO;
    srcEnByte[`TS_SRC_WIDTH-1:0] = sourceEnables;
    statusByte = `TS_BYTE_ZERO;
    statusByte[`TS_STAT_FULL] = recordFull; // R18
    statusByte[`TS_STAT_EMPTY] = recordEmpty; // R19
    statusByte[`TS_STAT_PTR_HI:`TS_STAT_PTR_LO] = latestSlot; // R20
  end

  // Register read port, one cycle of latency
  always @(posedge sys_clk)
  begin
    if (rst)
      regRdData <= `TS_BYTE_ZERO;
    else if (regRead)
    begin
      if (isRamAddr(regAddr))
        regRdData <= recordRam[ramIndex(regAddr)];
      else
      begin
        case (regAddr)
          `TS_ADDR_SUBSEC_LOW:  regRdData <= stampSubsecLow;
          `TS_ADDR_SUBSEC_HIGH: regRdData <= stampSubsecHigh;
          `TS_ADDR_SECONDS:     regRdData <= stampSeconds;
          `TS_ADDR_MINUTES:     regRdData <= stampMinutes;
          `TS_ADDR_HOURS:       regRdData <= stampHours;
          `TS_ADDR_WEEKDAY:     regRdData <= stampWeekday;
          `TS_ADDR_DAY:         regRdData <= stampDay;
          `TS_ADDR_MONTH:       regRdData <= stampMonth;
          `TS_ADDR_YEAR:        regRdData <= stampYear;
          `TS_ADDR_SNAPSHOT:    regRdData <= stampStatusSnapshot;
          `TS_ADDR_REC_CTRL:    regRdData <= ctrlByte; // R15
          `TS_ADDR_SRC_EN:      regRdData <= srcEnByte;
          `TS_ADDR_REC_STATUS:  regRdData <= statusByte; // R18 R19 R20
          default:              regRdData <= `TS_BYTE_ZERO;
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// ### rtl/ts_consts.vh
`ifndef TS_CONSTS_VH
`define TS_CONSTS_VH

// Register offsets
`define TS_ADDR_SUBSEC_LOW   8'h20
`define TS_ADDR_SUBSEC_HIGH  8'h21
`define TS_ADDR_SECONDS      8'h22
`define TS_ADDR_MINUTES      8'h23
`define TS_ADDR_HOURS        8'h24
`define TS_ADDR_WEEKDAY      8'h25
`define TS_ADDR_DAY          8'h26
`define TS_ADDR_MONTH        8'h27
`define TS_ADDR_YEAR         8'h28
`define TS_ADDR_SNAPSHOT     8'h29
`define TS_ADDR_REC_CTRL     8'h34
`define TS_ADDR_SRC_EN       8'h35
`define TS_ADDR_REC_STATUS   8'h36
`define TS_ADDR_RAM_BASE     8'h40
`define TS_ADDR_RAM_LAST     8'h7F

// Record control fields
`define TS_CTRL_IRQ_SEL      2
`define TS_CTRL_CLEAR        1
`define TS_CTRL_RAM_MODE     0

// Source enable fields
`define TS_SRC_CMP           3
`define TS_SRC_DET           2
`define TS_SRC_LOW           1
`define TS_SRC_OSC           0
`define TS_SRC_WIDTH         4

// Record status fields
`define TS_STAT_FULL         4
`define TS_STAT_EMPTY        3
`define TS_STAT_PTR_HI       2
`define TS_STAT_PTR_LO       0

// Snapshot fields
`define TS_SNAP_LOW          5
`define TS_SNAP_CMP          4
`define TS_SNAP_DET          3
`define TS_SNAP_OSC          1

// Record layout inside an 8-byte slot
`define TS_REC_SUBSEC        3'h0
`define TS_REC_SECONDS       3'h1
`define TS_REC_MINUTES       3'h2
`define TS_REC_HOURS         3'h3
`define TS_REC_DAY           3'h4
`define TS_REC_MONTH         3'h5
`define TS_REC_YEAR          3'h6
`define TS_REC_STATUS        3'h7
`define TS_REC_SUB512_BIT    0

// Reset and limit values
`define TS_PTR_RESET         3'h7
`define TS_PTR_STEP          3'h1
`define TS_COUNT_ZERO        4'h0
`define TS_COUNT_STEP        4'h1
`define TS_COUNT_FULL        4'h8
`define TS_BYTE_ZERO         8'h00

`endif

// ### rtl/ts_pin_sync.v
`timescale 1ns/100ps
`default_nettype none

module ts_pin_sync #(
  parameter WIDTH = 1
) (
  input  wire             sys_clk,
  input  wire             rst,
  input  wire [WIDTH-1:0] asyncIn,
  output reg  [WIDTH-1:0] syncOut
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  genvar i;

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
      stage3 <= {WIDTH{1'b0}};
    end
    else
    begin
      stage1 <= asyncIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // A change counts once the second and third stages agree
  generate
    for (i = 0; i < WIDTH; i = i + 1)
    begin : gAgree
      always @(posedge sys_clk)
      begin
        if (rst)
          syncOut[i] <= 1'b0;
        else if (stage2[i] == stage3[i])
          syncOut[i] <= stage3[i];
      end
    end
  endgenerate

endmodule
`default_nettype wire

// ### testbench/ts_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module ts_host_model (
  input  wire logic       sys_clk,
  input  wire logic [7:0] regRdData,
  output var  logic [7:0] regAddr,
  output var  logic [7:0] regWrData,
  output var  logic       regWrite,
  output var  logic       regRead,
  output var  logic       stampGlobalEnable
);
  initial
  begin
    regAddr = 8'h00;
    regWrData = 8'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    stampGlobalEnable = 1'b0;
  end
  // Bench drops the enable through this before stamp reads and record clears
  task automatic setEna(input logic v);
    @(posedge sys_clk);
    stampGlobalEnable <= v;
  endtask
  // One strobe per byte; the released data bus shows the inverse, the address holds
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge sys_clk);
    regWrite <= 1'b0;
    regWrData <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge sys_clk);
    regRead <= 1'b0;
    regAddr <= ~a;
    #1;
    d = regRdData;
  endtask
endmodule
`default_nettype wire

// ### testbench/ts_time_stamp_recorder_properties.sv
`timescale 1ns/100ps
`default_nettype none
module ts_time_stamp_recorder_properties (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [7:0] regAddr,
  input  wire logic       regRead,
  input  wire logic [7:0] regRdData,
  input  wire logic       stampGlobalEnable,
  input  wire logic       batteryLowFlag,
  input  wire logic       stampIrqPulse,
  input  wire logic       batteryLowDetected
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  chk_irq_off_next:
    assert property (!stampGlobalEnable |=> !stampIrqPulse) else $error("irq after stamping turned off");
  chk_irq_when_off:
    assert property ((!stampGlobalEnable) [*8] |-> !stampIrqPulse) else $error("irq while stamping off");
  chk_irq_needs_enable:
    assert property (stampIrqPulse |-> $past(stampGlobalEnable)) else $error("irq without enable");
  chk_lowdet_no_flag:
    assert property ((!batteryLowFlag) [*8] |-> !batteryLowDetected) else $error("low detect without flag");
  chk_read_data_holds:
    assert property (!regRead |=> $stable(regRdData)) else $error("read data changed without read");
  chk_clear_reads_zero:
    assert property (regRead && regAddr == 8'h34 |=> regRdData[1] == 1'b0 && regRdData[7:3] == 5'h00)
      else $error("record clear bit read back high");
  chk_full_status_ptr:
    assert property ((regRead && regAddr == 8'h36) ##1 regRdData[4] |-> regRdData[3:0] == 4'h7)
      else $error("full status with wrong empty or pointer");
  chk_status_unused:
    assert property (regRead && regAddr == 8'h36 |=> regRdData[7:5] == 3'h0 && !(regRdData[4] && regRdData[3]))
      else $error("status bits inconsistent");
  chk_snapshot_unused:
    assert property (regRead && regAddr == 8'h29 |=> regRdData[7:6] == 2'h0 && regRdData[2] == 1'b0
      && regRdData[0] == 1'b0) else $error("snapshot unused bit set");
  chk_subsec_low:
    assert property (regRead && regAddr == 8'h20 |=> regRdData[7:2] == 6'h00) else $error("subsec low upper bits set");
  cov_irq: cover property (stampIrqPulse);
  cov_full: cover property ((regRead && regAddr == 8'h36) ##1 regRdData[4]);
  cov_lowdet: cover property (batteryLowDetected);
endmodule
bind ts_time_stamp_recorder ts_time_stamp_recorder_properties i_ts_time_stamp_recorder_properties (
  .sys_clk(sys_clk), .rst(rst), .regAddr(regAddr), .regRead(regRead), .regRdData(regRdData),
  .stampGlobalEnable(stampGlobalEnable), .batteryLowFlag(batteryLowFlag), .stampIrqPulse(stampIrqPulse),
  .batteryLowDetected(batteryLowDetected));
`default_nettype wire

// ### testbench/ts_time_stamp_recorder_test.sv
`timescale 1ns/100ps
`default_nettype none
module ts_time_stamp_recorder_test;
  logic        sys_clk;
  logic        rst;
  logic [7:0]  regAddr;
  logic [7:0]  regWrData;
  logic [7:0]  regRdData;
  logic        regWrite;
  logic        regRead;
  logic        stampGlobalEnable;
  logic [4:0]  src;
  logic [9:0]  subsecCount;
  logic [7:0]  cal [7];
  logic        stampIrqPulse;
  logic        batteryLowDetected;
  logic        hit;
  logic        lowDet;
  logic [7:0]  d;
  int          n_fail;
  int          tests_run;
  logic [15:0] rows [6] = '{16'h360F, 16'h3400, 16'h3500, 16'h2000, 16'h2900, 16'h3000};

  ts_host_model i_ts_host_model (.sys_clk(sys_clk), .regRdData(regRdData), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .stampGlobalEnable(stampGlobalEnable));
  ts_time_stamp_recorder i_ts_time_stamp_recorder (.sys_clk(sys_clk), .rst(rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .stampGlobalEnable(stampGlobalEnable), .eventInputPin(src[4]), .batteryLowFlag(src[1]),
    .supplyBelowBatteryFlag(src[3]), .supplyDetectFlag(src[2]), .oscStopFlag(src[0]),
    .subsecCount(subsecCount), .calSeconds(cal[0]), .calMinutes(cal[1]), .calHours(cal[2]),
    .calWeekday(cal[3]), .calDay(cal[4]), .calMonth(cal[5]), .calYear(cal[6]),
    .stampIrqPulse(stampIrqPulse), .batteryLowDetected(batteryLowDetected));

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Raise the sources in m, watch for the pulse, then drop them
  task automatic trig(input logic [4:0] m, input logic exp);
    @(posedge sys_clk);
    src <= src | m;
    hit = 1'b0;
    repeat (12)
    begin
      @(posedge sys_clk);
      #1;
      if (stampIrqPulse === 1'b1)
        hit = 1'b1;
    end
    lowDet = batteryLowDetected;
    @(posedge sys_clk);
    src <= src & ~m;
    repeat (8) @(posedge sys_clk);
    check({7'h00, hit}, {7'h00, exp});
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    $display("unexpected at %0t: watchdog expired", $time);
    print_verdict;
  end

  initial
  begin
    rst = 1'b1;
    src = 5'h00;
    subsecCount = 10'h2A5;
    n_fail = 0;
    tests_run = 0;
    for (int i = 0; i < 7; i++)
      cal[i] = 8'(8'h11 * (i + 1));
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    foreach (rows[i])
    begin
      i_ts_host_model.rd(rows[i][15:8], d);
      check(d, rows[i][7:0]);
    end
    $display("reset test done");
    i_ts_host_model.setEna(1'b1);
    trig(5'h0F, 1'b0);
    check({7'h00, lowDet}, 8'h00);
    trig(5'h1F, 1'b1);
    i_ts_host_model.setEna(1'b0);
    i_ts_host_model.rd(8'h20, d);
    check(d, 8'h01);
    i_ts_host_model.rd(8'h21, d);
    check(d, 8'hA9);
    for (int i = 0; i < 7; i++)
    begin
      i_ts_host_model.rd(8'(8'h22 + i), d);
      check(d, cal[i]);
    end
    i_ts_host_model.rd(8'h29, d);
    check(d, 8'h1A);
    $display("stamp register test done");
    for (int i = 0; i < 4; i++)
    begin
      i_ts_host_model.wr(8'h35, 8'(1 << i));
      i_ts_host_model.setEna(1'b1);
      trig(5'(1 << i), 1'b1);
      if (i == 1)
        check({7'h00, lowDet}, 8'h01);
    end
    i_ts_host_model.wr(8'h35, 8'h00);
    $display("source test done");
    i_ts_host_model.wr(8'h34, 8'h05);
    i_ts_host_model.rd(8'h34, d);
    check(d, 8'h05);
    for (int k = 0; k < 9; k++)
    begin
      @(posedge sys_clk);
      cal[0] <= 8'(k);
      trig(5'h10, k == 7);
      i_ts_host_model.rd(8'h36, d);
      check(d, k < 7 ? 8'(k) : 8'h17);
    end
    i_ts_host_model.setEna(1'b0);
    i_ts_host_model.rd(8'h40, d);
    check(d, 8'hA9);
    for (int k = 0; k < 8; k++)
    begin
      i_ts_host_model.rd(8'(8'h41 + 8 * k), d);
      check(d, 8'(k));
    end
    $display("record test done");
    i_ts_host_model.wr(8'h34, 8'h05);
    i_ts_host_model.rd(8'h36, d);
    check(d, 8'h17);
    i_ts_host_model.wr(8'h34, 8'h07);
    i_ts_host_model.rd(8'h36, d);
    check(d, 8'h0F);
    i_ts_host_model.rd(8'h34, d);
    check(d, 8'h05);
    i_ts_host_model.wr(8'h50, 8'h3C);
    i_ts_host_model.rd(8'h50, d);
    check(d, 8'h3C);
    $display("clear test done");
    i_ts_host_model.wr(8'h34, 8'h00);
    trig(5'h10, 1'b0);
    i_ts_host_model.setEna(1'b1);
    trig(5'h10, 1'b1);
    $display("interrupt select test done");
    i_ts_host_model.wr(8'h7F, 8'hC3);
    i_ts_host_model.rd(8'h7F, d);
    check(d, 8'hC3);
    i_ts_host_model.wr(8'h34, 8'h05);
    trig(5'h10, 1'b0);
    i_ts_host_model.rd(8'h36, d);
    check(d, 8'h00);
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    i_ts_host_model.rd(8'h36, d);
    check(d, 8'h0F);
    i_ts_host_model.rd(8'h34, d);
    check(d, 8'h00);
    $display("mid-run reset test done");
    print_verdict;
  end
endmodule
`default_nettype wire
